// file: asm_pkg.sv
// Package: register map, field layouts and reset values of the status/mode bank
package asm_pkg;

  localparam int ASM_ADDR_W = 6;
  localparam int ASM_DATA_W = 16;
  localparam int ASM_NUM_CH = 4;

  // ------------------------------------------------------------
  // Register addresses
  // ------------------------------------------------------------
  localparam logic [5:0] ASM_ADDR_STATUS = 6'h01;
  localparam logic [5:0] ASM_ADDR_MODE = 6'h02;

  // ------------------------------------------------------------
  // Reset values and field codes
  // ------------------------------------------------------------
  localparam logic [15:0] ASM_MODE_RST = 16'h0510;
  localparam logic [15:0] ASM_MODE_WMASK = 16'h3F12;
  localparam logic [1:0] ASM_WLEN_16 = 2'h0;
  localparam logic [1:0] ASM_WLEN_24 = 2'h1;
  localparam logic [1:0] ASM_WLEN_32_ZPAD = 2'h2;
  localparam logic [1:0] ASM_WLEN_32_SEXT = 2'h3;
  localparam logic ASM_CRC_CCITT = 1'h0;
  localparam logic ASM_CRC_ANSI = 1'h1;

  // Mode register layout, bit 15 first
  typedef struct packed {
    logic [1:0] rsvd_15_14;
    logic regmap_crc_en;
    logic rx_crc_en;
    logic crc_type;
    logic reset_flag;
    logic [1:0] word_length_code;
    logic [2:0] rsvd_7_5;
    logic timeout_en;
    logic [1:0] rsvd_3_2;
    logic ready_pin_hiz;
    logic rsvd_0;
  } asm_mode_t;

  // Status word layout, bit 15 first
  typedef struct packed {
    logic lock;
    logic resync_occurred_flag;
    logic regmap_changed;
    logic rx_crc_error;
    logic crc_type;
    logic reset_flag;
    logic [1:0] word_length_code;
    logic [3:0] rsvd_7_4;
    logic [3:0] new_data_flags;
  } asm_status_t;

  // Host register access, one word per request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [5:0] addr;
    logic [15:0] wdata;
  } asm_reg_req_t;

endpackage

// file: asm_sticky.sv
// Sticky flag bank: hardware set beats a clear in the same cycle
`timescale 1ns/1ps
module asm_sticky #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Events and clears
  input wire logic [W-1:0] i_set,
  input wire logic [W-1:0] i_clr,
  // Flags
  output logic [W-1:0] o_flag
);

  wire [W-1:0] next_flag = i_set | (o_flag & ~i_clr);

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_flag <= '0;
    end else begin
      o_flag <= next_flag;
    end
  end

endmodule

// file: asm_status_mode.sv
// Status word and mode register bank of a four-channel sampling converter
// Function
// - Status bit 15 shows whether the serial interface is locked.
// - Status bit 14 sets on every converter resync; zero means none since the last status read.
// - Status bit 13 reads one when the register-map checksum changed.
// - Status bit 12 reads one after an incoming serial checksum error.
// - Status bit 11 shows checksum polynomial: zero CCITT, one ANSI.
// - Status bit 10 reads one after reset until the flag is cleared.
// - Status bits 9:8 give word length, reset 01; 00 is 16, 01 is 24 bits.
// - Code 10 is 32 bits zero padded low; 11 is 32 bits sign extended.
// - Status bits 3:0 flag new data on channels 3 to 0.
// - Mode register sits at address 02h and resets to 0510h.
// - Mode checksum-type field selects polynomial; status mirrors it.
// - Host writing zero to mode reset bit clears the status reset flag.
// - Mode word-length field selects output length with the same codes.
// - Register-map checksum monitoring runs only while its enable is one.
`timescale 1ns/1ps
module asm_status_mode
  import asm_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Register access from the serial framer
  input wire asm_pkg::asm_reg_req_t i_req,
  output logic [15:0] o_rdata,
  output logic o_rvalid,
  // Lock commands from the framer
  input wire logic i_lock_cmd,
  input wire logic i_unlock_cmd,
  // Converter and checksum events
  input wire logic i_resync_evt,
  input wire logic i_rx_crc_err_evt,
  input wire logic [15:0] i_regmap_crc,
  input wire logic [3:0] i_new_data_evt,
  input wire logic i_data_read,
  // Configuration and status seen by the rest of the device
  output asm_pkg::asm_mode_t o_mode,
  output asm_pkg::asm_status_t o_status,
  output logic [4:0] o_out_word_bits
);
  import asm_pkg::*;

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  logic lock;
  asm_mode_t mode;
  logic [15:0] crc_ref;
  logic crc_ref_valid;
  logic [2:0] evt_flags;
  logic [3:0] drdy_flags;

  wire hit_mode = i_req.addr == ASM_ADDR_MODE;
  wire hit_status = i_req.addr == ASM_ADDR_STATUS;
  // Locked interface refuses register writes
  wire mode_wr = i_req.wr && hit_mode && !lock;
  wire status_rd = i_req.rd && hit_status;

  function automatic logic [4:0] wlen_bits(input logic [1:0] code);
    case (code)
      ASM_WLEN_16: wlen_bits = 5'h10;
      ASM_WLEN_24: wlen_bits = 5'h18;
      default: wlen_bits = 5'h00;
    endcase
  endfunction

  // ------------------------------------------------------------
  // Lock state
  // ------------------------------------------------------------
  // lock indicator state
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      lock <= 1'b0;
    end else if (i_lock_cmd) begin
      lock <= 1'b1;
    end else if (i_unlock_cmd) begin
      lock <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Mode register
  // ------------------------------------------------------------
  // Reset bit can only be cleared by the host, never set
  wire [15:0] wr_masked = (i_req.wdata & ASM_MODE_WMASK) | (mode & ~ASM_MODE_WMASK);
  asm_mode_t next_mode;
  assign next_mode = asm_mode_t'({wr_masked[15:11], wr_masked[10] & mode.reset_flag,
                                  wr_masked[9:0]});

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      mode <= asm_mode_t'(ASM_MODE_RST);
    end else if (mode_wr) begin
      mode <= next_mode;
    end
  end

  // ------------------------------------------------------------
  // Register-map checksum monitor
  // ------------------------------------------------------------
  // monitor gated by enable
  wire mon_on = mode.regmap_crc_en;
  // A host write legitimately changes the map, so the reference is retaken
  wire regmap_evt = mon_on && crc_ref_valid && !mode_wr && (i_regmap_crc != crc_ref);

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      crc_ref <= 16'h0000;
      crc_ref_valid <= 1'b0;
    end else begin
      crc_ref <= i_regmap_crc;
      crc_ref_valid <= mon_on && !mode_wr;
    end
  end

  // ------------------------------------------------------------
  // Event flags
  // ------------------------------------------------------------
  // sticky, cleared by status read
  asm_sticky #(.W(3)) u_evt (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_set({i_resync_evt, regmap_evt, i_rx_crc_err_evt && mode.rx_crc_en}),
    .i_clr({3{status_rd}}),
    .o_flag(evt_flags)
  );

  asm_sticky #(.W(ASM_NUM_CH)) u_drdy (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_set(i_new_data_evt),
    .i_clr({ASM_NUM_CH{i_data_read}}),
    .o_flag(drdy_flags)
  );

  // ------------------------------------------------------------
  // Status word and read path
  // ------------------------------------------------------------
  asm_status_t status;
  // reserved bits zero, no write path
  assign status = '{lock: lock, resync_occurred_flag: evt_flags[2],
                    regmap_changed: evt_flags[1], rx_crc_error: evt_flags[0],
                    crc_type: mode.crc_type, reset_flag: mode.reset_flag,
                    word_length_code: mode.word_length_code, rsvd_7_4: 4'h0,
                    new_data_flags: drdy_flags};

  wire [15:0] rd_mux = hit_status ? status : hit_mode ? mode : 16'h0000;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_rdata <= 16'h0000;
      o_rvalid <= 1'b0;
      o_status <= '0;
      o_out_word_bits <= 5'h18;
    end else begin
      o_rdata <= i_req.rd ? rd_mux : o_rdata;
      o_rvalid <= i_req.rd;
      o_status <= status;
      // 32-bit codes, zero from function means 32
      o_out_word_bits <= (wlen_bits(mode.word_length_code) == 5'h00) ? 5'h00
                         : wlen_bits(mode.word_length_code);
    end
  end

  assign o_mode = mode;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sequence s_lock_req;
    i_lock_cmd;
  endsequence
  property p_lock;
    @(posedge i_clk) disable iff (i_sys_rst) s_lock_req |=> lock ##1 o_status.lock;
  endproperty
  a_lock: assert property (p_lock) else $error("lock not taken");

  property p_resync;
    @(posedge i_clk) disable iff (i_sys_rst) i_resync_evt |=> ##1 o_status.resync_occurred_flag;
  endproperty
  a_resync: assert property (p_resync) else $error("resync flag missed");

  property p_regmap_off;
    @(posedge i_clk) disable iff (i_sys_rst)
      (!mode.regmap_crc_en && (status_rd || !evt_flags[1])) |=> !evt_flags[1];
  endproperty
  a_regmap_off: assert property (p_regmap_off) else $error("monitor active when off");

  property p_crcerr;
    @(posedge i_clk) disable iff (i_sys_rst)
      (i_rx_crc_err_evt && mode.rx_crc_en) |=> evt_flags[0];
  endproperty
  a_crcerr: assert property (p_crcerr) else $error("crc error lost");

  property p_mirror;
    @(posedge i_clk) disable iff (i_sys_rst)
      !i_sys_rst |=> o_status[11:8] == $past(mode[11:8]) && o_status[7:4] == 4'h0;
  endproperty
  a_mirror: assert property (p_mirror) else $error("status mirror wrong");

  property p_rst_clear;
    @(posedge i_clk) disable iff (i_sys_rst)
      (mode_wr && !i_req.wdata[10]) |=> !mode.reset_flag ##1 !o_status.reset_flag;
  endproperty
  a_rst_clear: assert property (p_rst_clear) else $error("reset flag not cleared");

  property p_locked_wr;
    @(posedge i_clk) disable iff (i_sys_rst) (lock && i_req.wr) |=> $stable(mode);
  endproperty
  a_locked_wr: assert property (p_locked_wr) else $error("write while locked");

  property p_drdy;
    @(posedge i_clk) disable iff (i_sys_rst)
      (i_new_data_evt != 4'h0) |=>
        ((drdy_flags & $past(i_new_data_evt)) == $past(i_new_data_evt)) ##1
        ((o_status.new_data_flags & $past(i_new_data_evt, 2)) == $past(i_new_data_evt, 2));
  endproperty
  a_drdy: assert property (p_drdy) else $error("new data flag missed");

  property p_wlen;
    @(posedge i_clk) disable iff (i_sys_rst)
      (mode.word_length_code == ASM_WLEN_24) |=> o_out_word_bits == 5'h18;
  endproperty
  a_wlen: assert property (p_wlen) else $error("word length wrong");

endmodule

// file: asm_host_model.sv
// Host model: single-word register reads and writes over the framer port
`timescale 1ns/1ps
module asm_host_model
  import asm_pkg::*;
(
  // Clock and answer
  input wire logic i_clk,
  input wire logic [15:0] i_rdata,
  input wire logic i_rvalid,
  // Request
  output asm_pkg::asm_reg_req_t o_req
);
  initial o_req = '0;
  // Request held over its taking edge only, then released
  task automatic write_reg(input logic [5:0] a, input logic [15:0] d);
    @(posedge i_clk);
    o_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge i_clk);
    o_req <= '0;
  endtask
  // Answer registered, so sampled just after the taking edge
  task automatic read_reg(input logic [5:0] a, output logic [15:0] d, output logic v);
    @(posedge i_clk);
    o_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge i_clk);
    o_req <= '0;
    #1;
    v = i_rvalid;
    d = i_rdata;
  endtask
endmodule

// file: adc_status_mode_registers_tb.sv
// Testbench of the status word and mode register bank
`timescale 1ns/1ps
module adc_status_mode_registers_tb;
  import asm_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  asm_reg_req_t req;
  logic [15:0] rdata;
  logic rvalid, lk, ul, rs, ce, dr;
  logic [3:0] nd;
  logic [15:0] regcrc = 16'h0000;
  asm_mode_t mode;
  asm_status_t status;
  logic [4:0] owb;
  int n_mismatch = 0;
  int total_checks = 0;
  initial {lk, ul, rs, ce, dr, nd} = '0;
  always #10 clk = ~clk;
  asm_status_mode uut (.i_clk(clk), .i_sys_rst(rst), .i_req(req), .o_rdata(rdata),
    .o_rvalid(rvalid), .i_lock_cmd(lk), .i_unlock_cmd(ul), .i_resync_evt(rs),
    .i_rx_crc_err_evt(ce), .i_regmap_crc(regcrc), .i_new_data_evt(nd), .i_data_read(dr),
    .o_mode(mode), .o_status(status), .o_out_word_bits(owb));
  asm_host_model host (.i_clk(clk), .i_rdata(rdata), .i_rvalid(rvalid), .o_req(req));
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // One-cycle pulse on {lock, unlock, resync, crc err, data read, new data}
  task automatic ev(input logic [8:0] e);
    @(posedge clk);
    {lk, ul, rs, ce, dr, nd} <= e;
    @(posedge clk);
    {lk, ul, rs, ce, dr, nd} <= '0;
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    logic [15:0] d;
    logic v;
    host.read_reg(ASM_ADDR_STATUS, d, v);
    chk({15'h0, v}, 16'h0001, "rvalid");
    chk(d, 16'h0500, "status reset");
    host.read_reg(ASM_ADDR_MODE, d, v);
    chk(d, 16'h0510, "mode reset");
    chk({11'h0, owb}, 16'h0018, "word bits");
    $display("test reset done");
  endtask
  task automatic t_mode();
    logic [15:0] wd;
    for (int k = 0; k < 4; k++) begin
      wd = {4'hC, k[0], 1'b0, k[1:0], 8'hFF};
      host.write_reg(ASM_ADDR_MODE, wd);
      cyc(2);
      chk(mode, wd & 16'h3F12, "mode write");
      chk(status, {4'h0, k[0], 1'b0, k[1:0], 8'h00}, "status mirror");
      chk({11'h0, owb}, (k == 0) ? 16'h10 : (k == 1) ? 16'h18 : 16'h0, "bits");
    end
    host.write_reg(ASM_ADDR_MODE, 16'h0100);
    $display("test mode done");
  endtask
  task automatic t_events();
    logic [15:0] d;
    logic v;
    // Resync, gated-off checksum error, new data on channels 3 and 1
    ev(9'h06A);
    cyc(3);
    chk(status, 16'h410A, "events");
    host.write_reg(ASM_ADDR_STATUS, 16'hFFFF);
    cyc(2);
    chk(status, 16'h410A, "status write");
    host.read_reg(ASM_ADDR_STATUS, d, v);
    chk(d, 16'h410A, "status read");
    ev(9'h010);
    cyc(3);
    chk(status, 16'h0100, "cleared");
    host.write_reg(ASM_ADDR_MODE, 16'h1100);
    ev(9'h020);
    cyc(3);
    chk(status, 16'h1100, "rx crc err");
    $display("test events done");
  endtask
  task automatic t_lock();
    ev(9'h100);
    cyc(3);
    chk(status[15:8], 8'h91, "locked");
    host.write_reg(ASM_ADDR_MODE, 16'h0300);
    cyc(2);
    chk(mode, 16'h1100, "locked write");
    ev(9'h080);
    cyc(3);
    chk(status[15:8], 8'h11, "unlocked");
    $display("test lock done");
  endtask
  task automatic t_regmap();
    logic [15:0] d;
    logic v;
    host.read_reg(ASM_ADDR_STATUS, d, v);
    host.write_reg(ASM_ADDR_MODE, 16'h0100);
    @(posedge clk) regcrc <= 16'h1234;
    cyc(3);
    chk(status, 16'h0100, "monitor off");
    host.write_reg(ASM_ADDR_MODE, 16'h2100);
    cyc(4);
    @(posedge clk) regcrc <= 16'h4321;
    cyc(3);
    chk(status, 16'h2100, "map changed");
    $display("test regmap done");
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_mode();
    t_events();
    t_lock();
    t_regmap();
    give_verdict();
  end
  initial begin
    #200000;
    n_mismatch++;
    give_verdict();
  end
endmodule
